// *** design/rxq_host_path.sv ***
// receive frame queue with host register access over axi4-lite
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`include "rxq_defines.svh"
module rxq_host_path #(
    parameter int AW = 13,
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire rxq_pkg::rxq_wr_t rx_frame_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    output rxq_pkg::rxq_cfg_t rx_cfg_o,
    output logic irq_o
);
    localparam int DEPTH = 1 << AW;
    localparam int TICK_CYC = `RXQ_US_NS / `RXQ_CLK_NS;
    localparam logic [10:0] MAX_W = 11'(`RXQ_MAX_DATA_BYTES / 2);
    localparam logic [AW:0] FRAME_MAX = (AW+1)'(`RXQ_MAX_DATA_BYTES / 2 + 4);
    localparam logic [AW-1:0] W_STAT_OFS = AW'(`RXQ_HDR_STAT_OFS / 2);
    localparam logic [AW-1:0] W_BC_OFS = AW'(`RXQ_HDR_BC_OFS / 2);
    localparam logic [AW-1:0] W_DATA_OFS = AW'(`RXQ_DATA_OFS / 2);

    logic [15:0] mem [DEPTH];
    rxq_pkg::rxq_wst_t wst_reg;
    logic [AW-1:0] wp_reg, hp_reg, hdr_ptr_reg, mem_wa;
    logic [10:0] wcnt_reg;
    logic [11:0] wbc_reg, fcnt_reg, hdr_left_reg, wbytes;
    logic [15:0] wstat_reg, mem_wd;
    logic wpad_reg, mem_we, in_take, commit, rel;
    logic [AW:0] used_reg;
    logic [16:0] bytes_reg;
    logic [15:0] dur_reg, rxc1_reg, rxc2_reg, qctl_reg, dptr_reg, dtt_reg, dbt_reg, ier_reg;
    logic [7:0] tick_reg, fthr_reg, fcap_reg;
    logic isr13_reg, be_reg, dummy_reg, us_tick;
    logic [15:0] hdr_stat_reg;
    logic [11:0] hdr_bc_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // frame length in words, header included, rounded up to a double word
    function automatic logic [AW-1:0] fwords(input logic [11:0] bc);
        logic [12:0] q;
        q = ({1'b0, bc} + 13'h0003) >> 2;
        fwords = AW'(2) + AW'({q, 1'b0});
    endfunction : fwords

    function automatic logic [15:0] swap16(input logic [15:0] d, input logic en);
        swap16 = en ? {d[7:0], d[15:8]} : d;
    endfunction : swap16

    function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : merge

    function automatic logic mapped(input logic [7:0] i);
        case (i)
            `RXQ_IDX_RXC1, `RXQ_IDX_RXC2, `RXQ_IDX_HST, `RXQ_IDX_HBC, `RXQ_IDX_QCTL,
            `RXQ_IDX_DPTR, `RXQ_IDX_DTT, `RXQ_IDX_DBT, `RXQ_IDX_IER, `RXQ_IDX_ISR,
            `RXQ_IDX_FCTR, `RXQ_IDX_DATA, `RXQ_IDX_CFG: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    // bus decode: write address and data are taken together; a read and a write are accepted independently, one of each at a time
    logic wr_go, rd_go, w_map, r_map;
    logic [7:0] widx, ridx;
    logic w_qc, w_isr_clr, rd_data, rd_fctr, rd_hbc, auto_inc;
    logic [15:0] head_bc16, rd_val, rd_mem;
    logic [11:0] head_bc;
    logic [AW-1:0] rd_addr, hdr_nxt;
    assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_reg;
    assign rd_go = s_axi_arvalid_i & ~rvalid_reg;
    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o = wr_go;
    assign s_axi_arready_o = rd_go;
    assign widx = s_axi_awaddr_i[9:2];
    assign ridx = s_axi_araddr_i[9:2];
    assign w_map = mapped(widx) && (s_axi_awaddr_i[ADDR_W-1:10] == '0);
    assign r_map = mapped(ridx) && (s_axi_araddr_i[ADDR_W-1:10] == '0);
    assign w_qc = wr_go && w_map && widx == `RXQ_IDX_QCTL;
    assign w_isr_clr = wr_go && w_map && widx == `RXQ_IDX_ISR && s_axi_wstrb_i[1]
                       && s_axi_wdata_i[`RXQ_ISR_RX];
    assign rd_data = rd_go && r_map && ridx == `RXQ_IDX_DATA;
    assign rd_fctr = rd_go && r_map && ridx == `RXQ_IDX_FCTR;
    assign rd_hbc = rd_go && r_map && ridx == `RXQ_IDX_HBC;

    // head frame release: explicit bit 0, or dma end with auto dequeue on
    assign rel = w_qc && s_axi_wstrb_i[0] && (fcnt_reg != '0) && (s_axi_wdata_i[`RXQ_QC_REL]
                 || (qctl_reg[`RXQ_QC_DMA] && !s_axi_wdata_i[`RXQ_QC_DMA]
                     && qctl_reg[`RXQ_QC_AUTO]));
    assign head_bc16 = mem[hp_reg + W_BC_OFS];
    assign head_bc = head_bc16[11:0];

    // frame intake; a frame is only accepted when a worst-case frame fits
    assign rx_ready_o = (wst_reg == rxq_pkg::W_IDLE
                         && ((AW+1)'(DEPTH) - used_reg) >= FRAME_MAX)
                        || wst_reg == rxq_pkg::W_DATA || wst_reg == rxq_pkg::W_DROP;
    assign in_take = rx_valid_i & rx_ready_o;
    assign wbytes = (rx_frame_i.last && rx_frame_i.odd) ? 12'h001 : 12'h002;
    assign commit = wst_reg == rxq_pkg::W_BCNT;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wst_reg <= rxq_pkg::W_IDLE;
            wcnt_reg <= '0;
            wbc_reg <= '0;
            wstat_reg <= `RXQ_RST_REG;
            wpad_reg <= 1'b0;
            wp_reg <= '0;
        end else begin
            if (in_take) begin
                wstat_reg <= rx_frame_i.status; // last word's status wins
            end
            case (wst_reg)
                rxq_pkg::W_IDLE: if (in_take) begin
                    wpad_reg <= qctl_reg[`RXQ_QC_IPOFS];
                    wcnt_reg <= 11'h001;
                    wbc_reg <= (qctl_reg[`RXQ_QC_IPOFS] ? 12'h002 : 12'h000) + wbytes;
                    if (!rxc1_reg[`RXQ_C1_EN]) begin
                        wst_reg <= rx_frame_i.last ? rxq_pkg::W_IDLE : rxq_pkg::W_DROP;
                    end else begin
                        wst_reg <= rx_frame_i.last ? rxq_pkg::W_STAT : rxq_pkg::W_DATA;
                    end
                end
                rxq_pkg::W_DATA: if (rx_valid_i) begin
                    if (wcnt_reg < MAX_W) begin
                        wcnt_reg <= wcnt_reg + 11'h001;
                        wbc_reg <= wbc_reg + wbytes;
                    end
                    if (rx_frame_i.last) begin
                        wst_reg <= rxq_pkg::W_STAT;
                    end
                end
                rxq_pkg::W_DROP: if (rx_valid_i && rx_frame_i.last) begin
                    wst_reg <= rxq_pkg::W_IDLE;
                end
                rxq_pkg::W_STAT: wst_reg <= rxq_pkg::W_BCNT;
                rxq_pkg::W_BCNT: begin
                    wp_reg <= wp_reg + fwords(wbc_reg);
                    wst_reg <= rxq_pkg::W_IDLE;
                end
                default: wst_reg <= rxq_pkg::W_IDLE;
            endcase
        end
    end

    // one write port: data words, check sequence included, then header words
    always_comb begin
        mem_we = 1'b0;
        mem_wa = wp_reg;
        mem_wd = rx_frame_i.data;
        case (wst_reg)
            rxq_pkg::W_IDLE: if (in_take && rxc1_reg[`RXQ_C1_EN]) begin
                mem_we = 1'b1;
                mem_wa = wp_reg + W_DATA_OFS + AW'(qctl_reg[`RXQ_QC_IPOFS]);
            end
            rxq_pkg::W_DATA: if (rx_valid_i && wcnt_reg < MAX_W) begin
                mem_we = 1'b1;
                mem_wa = wp_reg + W_DATA_OFS + AW'(wpad_reg) + AW'(wcnt_reg);
            end
            rxq_pkg::W_STAT: begin
                mem_we = 1'b1;
                mem_wa = wp_reg + W_STAT_OFS;
                mem_wd = wstat_reg;
            end
            rxq_pkg::W_BCNT: begin
                mem_we = 1'b1;
                mem_wa = wp_reg + W_BC_OFS;
                mem_wd = {4'h0, wbc_reg};
            end
            default: mem_we = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // occupancy: frames, words and bytes held; commit and release may coincide
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fcnt_reg <= '0;
            used_reg <= '0;
            bytes_reg <= '0;
            hp_reg <= '0;
        end else begin
            fcnt_reg <= fcnt_reg + 12'(commit) - 12'(rel);
            used_reg <= used_reg + (commit ? (AW+1)'(fwords(wbc_reg)) : '0)
                        - (rel ? (AW+1)'(fwords(head_bc)) : '0);
            bytes_reg <= bytes_reg + (commit ? 17'(wbc_reg) : 17'h00000)
                         - (rel ? 17'(head_bc) : 17'h00000);
            if (rel) begin
                hp_reg <= hp_reg + fwords(head_bc);
            end
        end
    end

    // microsecond tick and head frame residence time, saturating
    assign us_tick = tick_reg == 8'(TICK_CYC - 1);
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tick_reg <= '0;
            dur_reg <= '0;
        end else begin
            tick_reg <= us_tick ? 8'h00 : tick_reg + 8'h01;
            if (rel || fcnt_reg == '0) begin
                dur_reg <= '0;
            end else if (us_tick && dur_reg != 16'hffff) begin
                dur_reg <= dur_reg + 16'h0001;
            end
        end
    end

    // threshold conditions, each gated by its own enable
    logic c_frm, c_byte, c_dur, c_any;
    assign c_frm = qctl_reg[`RXQ_QC_FEN] && fcnt_reg >= {4'h0, fthr_reg};
    assign c_byte = qctl_reg[`RXQ_QC_BEN] && bytes_reg > {1'b0, dbt_reg};
    assign c_dur = qctl_reg[`RXQ_QC_TEN] && fcnt_reg != '0 && dur_reg > dtt_reg;
    assign c_any = c_frm | c_byte | c_dur;

    // receive interrupt status; a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            isr13_reg <= 1'b0;
            fcap_reg <= '0;
        end else begin
            if (c_any) begin
                isr13_reg <= 1'b1;
            end else if (w_isr_clr) begin
                isr13_reg <= 1'b0;
            end
            if ((c_any && !isr13_reg) || w_isr_clr) begin
                fcap_reg <= (fcnt_reg > 12'h0ff) ? 8'hff : fcnt_reg[7:0];
            end
        end
    end
    assign irq_o = |({2'b00, isr13_reg, 13'h0000} & ier_reg);

    // software-written settings
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rxc1_reg <= `RXQ_RST_REG;
            rxc2_reg <= `RXQ_RST_REG;
            qctl_reg <= `RXQ_RST_REG;
            dtt_reg <= `RXQ_RST_REG;
            dbt_reg <= `RXQ_RST_REG;
            ier_reg <= `RXQ_RST_REG;
            fthr_reg <= '0;
            be_reg <= 1'b0;
        end else if (wr_go && w_map) begin
            case (widx)
                `RXQ_IDX_RXC1: rxc1_reg <= merge(rxc1_reg, s_axi_wdata_i, s_axi_wstrb_i);
                `RXQ_IDX_RXC2: rxc2_reg <= merge(rxc2_reg, s_axi_wdata_i, s_axi_wstrb_i);
                `RXQ_IDX_QCTL: qctl_reg <= merge(qctl_reg, s_axi_wdata_i, s_axi_wstrb_i)
                                           & `RXQ_QC_RW_MASK;
                `RXQ_IDX_DTT: dtt_reg <= merge(dtt_reg, s_axi_wdata_i, s_axi_wstrb_i);
                `RXQ_IDX_DBT: dbt_reg <= merge(dbt_reg, s_axi_wdata_i, s_axi_wstrb_i);
                `RXQ_IDX_IER: ier_reg <= merge(ier_reg, s_axi_wdata_i, s_axi_wstrb_i);
                `RXQ_IDX_FCTR: if (s_axi_wstrb_i[0]) fthr_reg <= s_axi_wdata_i[7:0];
                `RXQ_IDX_CFG: if (s_axi_wstrb_i[0]) be_reg <= s_axi_wdata_i[0];
                default: be_reg <= be_reg;
            endcase
        end
    end
    assign rx_cfg_o = '{ctrl_one: rxc1_reg, ctrl_two: rxc2_reg,
                        flow_en: rxc1_reg[`RXQ_C1_FLOW]};

    // dma reads: pointer is a byte offset from the head frame's status word
    assign rd_addr = hp_reg + AW'(dptr_reg[10:1]);
    assign rd_mem = swap16(mem[rd_addr], be_reg && dptr_reg[10:0] < 11'(`RXQ_DATA_OFS));
    assign auto_inc = rd_data && qctl_reg[`RXQ_QC_DMA] && !dummy_reg && dptr_reg[`RXQ_DP_AUTO];
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dptr_reg <= `RXQ_RST_REG;
            dummy_reg <= 1'b0;
        end else begin
            if (w_qc && s_axi_wstrb_i[0] && s_axi_wdata_i[`RXQ_QC_DMA]
                && !qctl_reg[`RXQ_QC_DMA]) begin
                dummy_reg <= 1'b1;
            end else if (rd_data) begin
                dummy_reg <= 1'b0; // a read with dma off disarms too; a new start re-arms
            end
            if (wr_go && w_map && widx == `RXQ_IDX_DPTR) begin
                dptr_reg <= merge(dptr_reg, s_axi_wdata_i, s_axi_wstrb_i) & 16'h47ff;
            end else if (rel) begin
                dptr_reg[10:0] <= '0;
            end else if (auto_inc) begin
                dptr_reg[10:0] <= dptr_reg[10:0] + 11'h002;
            end
        end
    end

    // header registers: counter read loads head, byte count read steps on
    assign hdr_nxt = hdr_ptr_reg + fwords(hdr_bc_reg);
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hdr_ptr_reg <= '0;
            hdr_stat_reg <= `RXQ_RST_REG;
            hdr_bc_reg <= '0;
            hdr_left_reg <= '0;
        end else if (rd_fctr) begin
            hdr_ptr_reg <= hp_reg;
            hdr_stat_reg <= mem[hp_reg + W_STAT_OFS];
            hdr_bc_reg <= head_bc;
            hdr_left_reg <= fcnt_reg;
        end else if (rd_hbc && hdr_left_reg > 12'h001) begin
            hdr_ptr_reg <= hdr_nxt;
            hdr_stat_reg <= mem[hdr_nxt + W_STAT_OFS];
            hdr_bc_reg <= mem[hdr_nxt + W_BC_OFS][11:0];
            hdr_left_reg <= hdr_left_reg - 12'h001;
        end
    end

    // read data mux
    always_comb begin
        case (ridx)
            `RXQ_IDX_RXC1: rd_val = rxc1_reg;
            `RXQ_IDX_RXC2: rd_val = rxc2_reg;
            `RXQ_IDX_HST: rd_val = swap16(hdr_stat_reg, be_reg);
            `RXQ_IDX_HBC: rd_val = swap16({4'h0, hdr_bc_reg}, be_reg);
            `RXQ_IDX_QCTL: rd_val = qctl_reg | {3'b000, c_dur, c_byte, c_frm, 10'h000};
            `RXQ_IDX_DPTR: rd_val = dptr_reg;
            `RXQ_IDX_DTT: rd_val = dtt_reg;
            `RXQ_IDX_DBT: rd_val = dbt_reg;
            `RXQ_IDX_IER: rd_val = ier_reg;
            `RXQ_IDX_ISR: rd_val = {2'b00, isr13_reg, 13'h0000};
            `RXQ_IDX_FCTR: rd_val = {fcap_reg, fthr_reg};
            `RXQ_IDX_DATA: rd_val = qctl_reg[`RXQ_QC_DMA] && !dummy_reg ? rd_mem : 16'h0000;
            `RXQ_IDX_CFG: rd_val = {15'h0000, be_reg};
            default: rd_val = 16'h0000;
        endcase
    end

    // responses one cycle after acceptance; unmapped answers decode error
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'b00;
            rdata_reg <= '0;
        end else begin
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= w_map ? 2'b00 : 2'b11;
            end else if (s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= r_map ? 2'b00 : 2'b11;
                rdata_reg <= r_map ? {16'h0000, rd_val} : 32'h00000000;
            end else if (s_axi_rready_i) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign s_axi_rdata_o = rdata_reg;

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_arm;
        w_qc && s_axi_wstrb_i[0] && s_axi_wdata_i[`RXQ_QC_DMA] && !qctl_reg[`RXQ_QC_DMA];
    endsequence
    sequence s_first_rd;
        rd_data && dummy_reg && r_map;
    endsequence
    property p_arm;
        s_arm |=> dummy_reg ##0 qctl_reg[`RXQ_QC_DMA];
    endproperty
    a_arm: assert property (p_arm) else $error("dma start did not arm dummy");
    property p_dummy;
        s_first_rd |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h00000000 && !dummy_reg;
    endproperty
    a_dummy: assert property (p_dummy) else $error("first dma read not dummy");
    property p_hdr_write;
        wst_reg == rxq_pkg::W_STAT |-> mem_we && mem_wa == wp_reg && !rx_ready_o
            ##1 mem_we && mem_wa == wp_reg + AW'(1);
    endproperty
    a_hdr_write: assert property (p_hdr_write) else $error("header words misplaced");
    property p_trunc;
        wst_reg == rxq_pkg::W_DATA && wcnt_reg >= MAX_W |-> !mem_we;
    endproperty
    a_trunc: assert property (p_trunc) else $error("frame stored beyond limit");
    property p_isr_set;
        c_any |=> isr13_reg;
    endproperty
    a_isr_set: assert property (p_isr_set) else $error("threshold lost");
    property p_isr_clr;
        w_isr_clr && !c_any |=> !isr13_reg;
    endproperty
    a_isr_clr: assert property (p_isr_clr) else $error("write one did not clear");
    property p_irq;
        isr13_reg && ier_reg[`RXQ_ISR_RX] |-> irq_o ##0 !(ier_reg == '0 && irq_o);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    property p_autoinc;
        auto_inc && !(wr_go && widx == `RXQ_IDX_DPTR) && !rel
            |=> dptr_reg[10:0] == $past(dptr_reg[10:0]) + 11'h002;
    endproperty
    a_autoinc: assert property (p_autoinc) else $error("pointer did not step");
    property p_fcap;
        $rose(isr13_reg) && $past(fcnt_reg) < 12'h100 |-> fcap_reg == $past(fcnt_reg[7:0]);
    endproperty
    a_fcap: assert property (p_fcap) else $error("frame total not captured");
    property p_hdr_load;
        rd_fctr |=> hdr_ptr_reg == $past(hp_reg) && hdr_left_reg == $past(fcnt_reg);
    endproperty
    a_hdr_load: assert property (p_hdr_load) else $error("header not loaded");
endmodule : rxq_host_path

// *** inc/rxq_defines.svh ***
// register indexes, field positions, reset values and timing for the receive queue
`ifndef RXQ_DEFINES_SVH
`define RXQ_DEFINES_SVH
`define RXQ_IDX_RXC1 8'h74
`define RXQ_IDX_RXC2 8'h76
`define RXQ_IDX_HST 8'h7c
`define RXQ_IDX_HBC 8'h7e
`define RXQ_IDX_QCTL 8'h82
`define RXQ_IDX_DPTR 8'h86
`define RXQ_IDX_DTT 8'h8c
`define RXQ_IDX_DBT 8'h8e
`define RXQ_IDX_IER 8'h90
`define RXQ_IDX_ISR 8'h92
`define RXQ_IDX_FCTR 8'h9c
`define RXQ_IDX_DATA 8'ha0
`define RXQ_IDX_CFG 8'ha2
`define RXQ_C1_FLOW 10
`define RXQ_C1_EN 0
`define RXQ_QC_REL 0
`define RXQ_QC_DMA 3
`define RXQ_QC_AUTO 4
`define RXQ_QC_FEN 5
`define RXQ_QC_BEN 6
`define RXQ_QC_TEN 7
`define RXQ_QC_IPOFS 9
`define RXQ_QC_FST 10
`define RXQ_QC_BST 11
`define RXQ_QC_TST 12
`define RXQ_QC_RW_MASK 16'h02f8
`define RXQ_DP_AUTO 14
`define RXQ_ISR_RX 13
`define RXQ_HDR_STAT_OFS 0
`define RXQ_HDR_BC_OFS 2
`define RXQ_DATA_OFS 4
`define RXQ_RST_REG 16'h0000
`define RXQ_US_NS 1000
`define RXQ_CLK_NS 8
`define RXQ_MAX_DATA_BYTES 2000
`endif

// *** inc/rxq_pkg.sv ***
// types shared by the receive queue design
package rxq_pkg;
    // one 16-bit word of an incoming frame from the receive mac
    typedef struct packed {
        logic [15:0] data;
        logic [15:0] status;
        logic last;
        logic odd;
    } rxq_wr_t;
    // settings handed to the receive mac and checksum logic
    typedef struct packed {
        logic [15:0] ctrl_one;
        logic [15:0] ctrl_two;
        logic flow_en;
    } rxq_cfg_t;
    typedef enum logic [2:0] {W_IDLE, W_DATA, W_DROP, W_STAT, W_BCNT} rxq_wst_t;
endpackage : rxq_pkg

// *** bench/rxq_mac_model.sv ***
// receive mac stand-in feeding frame words to the queue
`timescale 1ns/10ps
module rxq_mac_model (
    input wire logic sys_clk_i,
    input wire logic go_i,
    input wire logic [3:0] len_i,
    input wire logic rx_ready_i,
    output rxq_pkg::rxq_wr_t frame_o,
    output logic valid_o
);
    initial begin
        valid_o = 1'b0;
        frame_o = '0;
    end
    // word k holds bytes 2k, 2k+1; idle data toggles so stale words never look valid
    always @(posedge sys_clk_i) begin
        if (go_i) begin
            for (int k = 0; k < len_i; k++) begin
                frame_o <= '{16'h1100 + 16'(k), 16'h8001, k == len_i - 1, 1'b0};
                valid_o <= 1'b1;
                @(negedge sys_clk_i) while (!rx_ready_i) @(negedge sys_clk_i);
                @(posedge sys_clk_i);
            end
            valid_o <= 1'b0;
        end else begin
            frame_o <= ~frame_o;
        end
    end
endmodule : rxq_mac_model

// *** bench/test_rxq_host_path.sv ***
// self-checking bench for the receive queue host path
`timescale 1ns/10ps
module test_rxq_host_path;
    logic clk = 0, rst_n = 0, aw = 0, w = 0, b = 0, ar = 0, r = 0, go = 0;
    logic awr, wrr, bv, arr, rv, rxv, rdy, irq;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, lfsr = 32'h3de7;
    logic [1:0] bresp, rresp;
    logic [3:0] len = 0;
    logic [33:0] got;
    rxq_pkg::rxq_wr_t frm;
    rxq_pkg::rxq_cfg_t cfg;
    int n_fail = 0, tests_run = 0;
    always #4 clk = ~clk;
    rxq_host_path uut (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(aw), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'h3), .s_axi_wvalid_i(w), .s_axi_wready_o(wrr),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(b),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(ar), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(r), .rx_frame_i(frm), .rx_valid_i(rxv), .rx_ready_o(rdy),
        .rx_cfg_o(cfg), .irq_o(irq));
    rxq_mac_model mac (.sys_clk_i(clk), .go_i(go), .len_i(len), .rx_ready_i(rdy),
        .frame_o(frm), .valid_o(rxv));
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // random source for frame lengths
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // stored byte count: two bytes per word, two more when the offset is on
    function automatic logic [15:0] exp_bc(input logic [3:0] n, input logic pad);
        exp_bc = {11'h000, n, 1'b0} + (pad ? 16'h0002 : 16'h0000);
    endfunction : exp_bc
    // writes hold both channels until taken, then wait for the answer
    task automatic wreg(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk);
        awa <= a;
        wd <= {16'h0000, v};
        aw <= 1'b1;
        w <= 1'b1;
        b <= 1'b1;
        @(negedge clk) while (!(awr && wrr)) @(negedge clk);
        @(posedge clk);
        aw <= 1'b0;
        w <= 1'b0;
        @(negedge clk) while (!bv) @(negedge clk);
        @(posedge clk);
        b <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [11:0] a, input logic [1:0] er, input logic [15:0] ev);
        @(posedge clk);
        ara <= a;
        ar <= 1'b1;
        r <= 1'b1;
        @(negedge clk) while (!arr) @(negedge clk);
        @(posedge clk);
        ar <= 1'b0;
        @(negedge clk) while (!rv) @(negedge clk);
        got = {rresp, rd};
        @(posedge clk);
        r <= 1'b0;
        chk(got, {er, 16'h0000, ev});
    endtask : rreg
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // watchdog sized well past the 140 or so cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rreg(12'h1d0, 2'b00, 16'h0000);
        wreg(12'h1d0, 16'h0401);
        rreg(12'h1d0, 2'b00, 16'h0401);
        chk(cfg.flow_en, 1'b1);
        rreg(12'h300, 2'b11, 16'h0000);
        $display("register test done");
        wreg(12'h270, 16'h0001);
        wreg(12'h208, 16'h0020);
        wreg(12'h240, 16'h2000);
        lfsr = lfsr_next(lfsr);
        @(posedge clk);
        len <= 4'(2 + lfsr[1:0]);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk);
        chk(irq, 1'b1);
        rreg(12'h208, 2'b00, 16'h0420);
        rreg(12'h270, 2'b00, 16'h0101);
        rreg(12'h1f0, 2'b00, 16'h8001);
        rreg(12'h1f8, 2'b00, exp_bc(len, 1'b0));
        wreg(12'h288, 16'h0001);
        rreg(12'h1f0, 2'b00, 16'h0180);
        wreg(12'h288, 16'h0000);
        wreg(12'h240, 16'h0000);
        chk(irq, 1'b0);
        $display("threshold test done");
        wreg(12'h218, 16'h4000);
        wreg(12'h208, 16'h0028);
        rreg(12'h280, 2'b00, 16'h0000);
        rreg(12'h280, 2'b00, 16'h8001);
        rreg(12'h280, 2'b00, exp_bc(len, 1'b0));
        rreg(12'h280, 2'b00, 16'h1100);
        rreg(12'h280, 2'b00, 16'h1101);
        $display("dma test done");
        wreg(12'h208, 16'h0038);
        wreg(12'h208, 16'h0030);
        rreg(12'h208, 2'b00, 16'h0030);
        rreg(12'h218, 2'b00, 16'h4000);
        wreg(12'h248, 16'hffff);
        rreg(12'h248, 2'b00, 16'h0000);
        $display("dequeue test done");
        wreg(12'h208, 16'h0220);
        lfsr = lfsr_next(lfsr);
        @(posedge clk);
        len <= 4'(2 + lfsr[1:0]);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
        rreg(12'h270, 2'b00, 16'h0101);
        rreg(12'h1f8, 2'b00, exp_bc(len, 1'b1));
        $display("offset test done");
        tally_and_finish();
    end
endmodule : test_rxq_host_path
